// File: rtl/ccr_params.svh
// Offsets, field positions and reset values of the card/device control bank.
// Definitions only; included by ccr_func_regs and ccr_top of the bank.
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets in configuration space
// ----------------------------------------------------------------------------
`define CCR_OFF_CARD     8'h91
`define CCR_OFF_DEV      8'h92

// ----------------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------------
`define CCR_CARD_RST     8'h00
`define CCR_DEV_RST      8'h66
`define CCR_CARD_WMASK   8'he6
`define CCR_DEV_WMASK    8'hef
`define CCR_RDATA_RST    8'h00

// ----------------------------------------------------------------------------
// Card control field positions
// ----------------------------------------------------------------------------
`define CCR_CC_RING      7
`define CCR_CC_VID       6
`define CCR_CC_PRIO      5
`define CCR_CC_AUDIO     2
`define CCR_CC_SPK       1
`define CCR_CC_IFG       0

// ----------------------------------------------------------------------------
// Device control field positions
// ----------------------------------------------------------------------------
`define CCR_DC_LOCK      7
`define CCR_DC_LOWV      6
`define CCR_DC_DIAG      5
`define CCR_DC_TEST      3
`define CCR_DC_MODE_HI   2
`define CCR_DC_MODE_LO   1
`define CCR_DC_NAND      0

// Number of socket functions and of synchronised card pins
`define CCR_NUM_SOCK     2
`define CCR_NUM_PINS     8

`endif

// File: rtl/ccr_pkg.sv
// Types shared by the card/device control bank.
// Assumes the constants header is included by the modules that use it.
package ccr_pkg;

  // Interrupt delivery mode, device control bits 2:1
  typedef enum logic [1:0] {
    CCR_MODE_PAR_PCI   = 2'h0,
    CCR_MODE_PAR_BOTH  = 2'h1,
    CCR_MODE_SER_IRQ   = 2'h2,
    CCR_MODE_SER_BOTH  = 2'h3
  } ccr_irq_mode_type;

  // One configuration byte
  typedef logic [7:0] ccr_byte_type;

endpackage

// File: rtl/ccr_sync2.sv
// Two-stage synchroniser for a vector of card-side pins.
// Assumes each bit is an independent level; no bus coherency is kept.
`timescale 1ns/10ps

module ccr_sync2 #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Pin side and synchronised side
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;  // Read only by the second stage
  logic [WIDTH-1:0] stage2;  // Safe to use in logic

  // ---------------------------------------------------------------------------
  // Two flops; metastability settles in the first
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
    end
  end

  assign sync_o = stage2;

endmodule

// File: rtl/ccr_func_regs.sv
// Card control and device control registers of one socket function.
// Assumes write strobes are one-cycle pulses decoded by the parent.
`timescale 1ns/10ps

module ccr_func_regs
  import ccr_pkg::*;
(
  // Clock and global reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Write port
  input  wire logic         wr_card_i,
  input  wire logic         wr_dev_i,
  input  wire ccr_byte_type wdata_i,
  // Synchronised functional interrupt of this socket
  input  wire logic         irq_event_i,
  // Register contents
  output ccr_byte_type      card_control_o,
  output ccr_byte_type      device_control_o
);

  `include "ccr_params.svh"

  ccr_byte_type card_control;       // Stored card control
  ccr_byte_type device_control;     // Stored device control
  ccr_byte_type next_card_control;
  ccr_byte_type next_device_control;

  // ---------------------------------------------------------------------------
  // Next values: masked writes, sticky flag
  // ---------------------------------------------------------------------------
  always_comb begin
    next_card_control   = card_control;
    next_device_control = device_control;
    // Reserved bits never take write data, so they stay zero
    if (wr_card_i) begin
      next_card_control = (card_control & ~`CCR_CARD_WMASK) | (wdata_i & `CCR_CARD_WMASK);
    end
    // A pending interrupt beats a write-one clear in the same cycle
    if (irq_event_i) begin
      next_card_control[`CCR_CC_IFG] = 1'b1;
    end else if (wr_card_i && wdata_i[`CCR_CC_IFG]) begin
      next_card_control[`CCR_CC_IFG] = 1'b0;
    end else begin
      next_card_control[`CCR_CC_IFG] = card_control[`CCR_CC_IFG];
    end
    // Bit 4 is read-only zero; test bit 3 stores as written
    if (wr_dev_i) begin
      next_device_control = (device_control & ~`CCR_DEV_WMASK) | (wdata_i & `CCR_DEV_WMASK);
    end
  end

  // ---------------------------------------------------------------------------
  // Storage, cleared only by the global reset
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      card_control   <= `CCR_CARD_RST;
      device_control <= `CCR_DEV_RST;
    end else begin
      card_control   <= next_card_control;
      device_control <= next_device_control;
    end
  end

  assign card_control_o   = card_control;
  assign device_control_o = device_control;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  chk_irq_flag_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    irq_event_i |=> card_control[`CCR_CC_IFG])
    else $error("interrupt flag not set by card event");

  chk_irq_flag_clr: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_card_i && !irq_event_i) |=>
      (card_control[`CCR_CC_IFG] == ($past(card_control[`CCR_CC_IFG]) &&
                                    !$past(wdata_i[`CCR_CC_IFG]))))
    else $error("interrupt flag write-one-clear wrong");

  chk_rsvd_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (card_control[4:3] == 2'h0) && (device_control[4] == 1'b0))
    else $error("reserved bit not zero");

endmodule

// File: rtl/ccr_top.sv
// Card control and device control bank for a two-socket card bridge.
// Assumes configuration cycles arrive as one-cycle strobes on clk_i with
// a byte offset and a function number; card pins are asynchronous.
//
// Behaviour
// - Ring enable bit gates ring-indicate output.
// - Video enable tri-states that socket's video port.
// - Priority bit picks socket when both video-enabled.
// - Card control bits 4:3 read zero.
// - Audio mux zero drives card audio PWM.
// - Speaker enable passes card speaker to host.
// - Socket functional interrupt sets its flag.
// - Writing one clears flag; zero keeps it.
// - Only global reset clears these registers.
// - Power lock blocks power-down while in D3.
// - Low-voltage force bit reports capability, resets one.
// - Diagnostic bit is read/write, resets one.
// - Device control bit 4 reads zero, unwritable.
// - Test bit shortens interrogation counter; write zero.
// - Mode bits select interrupt delivery scheme.
// - Diagnostic enable runs NAND chain over inputs.
// - Status-change interrupts follow external routing control.
`timescale 1ns/10ps

module ccr_top
  import ccr_pkg::*;
(
  // Clock and global reset (asynchronous, active high)
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Configuration access
  input  wire logic         cfg_write_i,
  input  wire logic         cfg_read_i,
  input  wire logic         cfg_func_i,
  input  wire logic [7:0]   cfg_offset_i,
  input  wire ccr_byte_type cfg_wdata_i,
  output ccr_byte_type      cfg_rdata_o,
  output logic              cfg_rvalid_o,
  // Card-side pins, one bit per socket, asynchronous
  input  wire logic [1:0]   card_func_irq_i,
  input  wire logic [1:0]   card_ring_i,
  input  wire logic [1:0]   card_audio_i,
  input  wire logic [1:0]   card_speaker_i,
  // Power management requests, same clock
  input  wire logic [1:0]   power_off_req_i,
  input  wire logic [1:0]   power_on_req_i,
  input  wire logic [1:0]   d3_state_i,
  // Status-change interrupts and their routing permit, same clock
  input  wire logic [1:0]   status_change_irq_i,
  input  wire logic         csc_route_i,
  // Card services
  output logic              ring_indicate_output_o,
  output logic [1:0]        video_port_hiz_o,
  output logic              video_select0_n_o,
  output logic              video_select1_n_o,
  output logic              card_audio_pwm_o,
  output logic              host_speaker_out_o,
  output logic [1:0]        card_irq_pending_o,
  // Device behaviour
  output logic [1:0]        socket_power_off_o,
  output logic [1:0]        low_volt_capable_o,
  output logic [1:0]        test_short_count_o,
  output ccr_irq_mode_type  irq_signal_mode0_o,
  output ccr_irq_mode_type  irq_signal_mode1_o,
  output logic              status_change_pci_o,
  output logic              nand_tree_en_o,
  output logic              nand_tree_out_o
);

  `include "ccr_params.svh"

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [`CCR_NUM_PINS-1:0] pins_sync;        // Synchronised card pins
  logic [1:0]               irq_s;            // Functional interrupt, per socket
  logic [1:0]               ring_s;           // Ring indicate, per socket
  logic [1:0]               aud_s;            // Card audio, per socket
  logic [1:0]               spk_s;            // Card speaker, per socket
  logic [1:0]               wr_card;          // Card control write strobe
  logic [1:0]               wr_dev;           // Device control write strobe
  ccr_byte_type             card_reg [2];     // Card control per socket
  ccr_byte_type             dev_reg  [2];     // Device control per socket
  logic [1:0]               ring_en;          // Ring output enables
  logic [1:0]               vid_en;           // Video compatibility enables
  logic [1:0]               audio_mux;        // One means audio not routed
  logic [1:0]               spk_en;           // Speaker pass enables
  logic [1:0]               lock;             // Power lock bits
  logic [1:0]               nand_en;          // NAND chain enables
  logic [`CCR_NUM_PINS-1:0] nand_chain;       // NAND chain taps

  ccr_byte_type             next_rdata;
  logic                     next_rvalid;
  logic                     next_ring;
  logic                     next_sel0_n;
  logic                     next_sel1_n;
  logic                     next_audio;
  logic                     next_speaker;
  logic [1:0]               power_off;
  logic [1:0]               next_power_off;
  logic                     next_csc;
  logic                     next_nand_out;
  logic                     next_nand_en;

  // Offset match, shared by write and read decode
  function automatic logic is_offset(input logic [7:0] off, input logic [7:0] target);
    is_offset = (off == target);
  endfunction

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  ccr_sync2 #(
    .WIDTH (`CCR_NUM_PINS)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({card_speaker_i, card_audio_i, card_ring_i, card_func_irq_i}),
    .sync_o  (pins_sync)
  );

  assign irq_s  = pins_sync[1:0];
  assign ring_s = pins_sync[3:2];
  assign aud_s  = pins_sync[5:4];
  assign spk_s  = pins_sync[7:6];

  // ---------------------------------------------------------------------------
  // Per-socket register copies
  // ---------------------------------------------------------------------------
  // Each function has its own bank, so one socket never disturbs the other
  for (genvar s = 0; s < `CCR_NUM_SOCK; s++) begin : g_sock
    assign wr_card[s] = cfg_write_i && (cfg_func_i == s[0])
                        && is_offset(cfg_offset_i, `CCR_OFF_CARD);
    assign wr_dev[s]  = cfg_write_i && (cfg_func_i == s[0])
                        && is_offset(cfg_offset_i, `CCR_OFF_DEV);

    ccr_func_regs u_regs (
      .clk_i            (clk_i),
      .rst_i            (rst_i),
      .wr_card_i        (wr_card[s]),
      .wr_dev_i         (wr_dev[s]),
      .wdata_i          (cfg_wdata_i),
      .irq_event_i      (irq_s[s]),
      .card_control_o   (card_reg[s]),
      .device_control_o (dev_reg[s])
    );

    // Field taps
    assign ring_en[s]            = card_reg[s][`CCR_CC_RING];
    assign vid_en[s]             = card_reg[s][`CCR_CC_VID];
    assign audio_mux[s]          = card_reg[s][`CCR_CC_AUDIO];
    assign spk_en[s]             = card_reg[s][`CCR_CC_SPK];
    assign lock[s]               = dev_reg[s][`CCR_DC_LOCK];
    assign nand_en[s]            = dev_reg[s][`CCR_DC_NAND];
    // Register-driven outputs
    assign video_port_hiz_o[s]   = card_reg[s][`CCR_CC_VID];
    assign card_irq_pending_o[s] = card_reg[s][`CCR_CC_IFG];
    assign low_volt_capable_o[s] = dev_reg[s][`CCR_DC_LOWV];
    assign test_short_count_o[s] = dev_reg[s][`CCR_DC_TEST];
  end

  // Interrupt delivery mode per socket
  assign irq_signal_mode0_o =
    ccr_irq_mode_type'(dev_reg[0][`CCR_DC_MODE_HI:`CCR_DC_MODE_LO]);
  assign irq_signal_mode1_o =
    ccr_irq_mode_type'(dev_reg[1][`CCR_DC_MODE_HI:`CCR_DC_MODE_LO]);

  // ---------------------------------------------------------------------------
  // Configuration read
  // ---------------------------------------------------------------------------
  // Unmapped offsets answer zero so the caller always gets a byte back
  always_comb begin
    next_rvalid = cfg_read_i;
    next_rdata  = `CCR_RDATA_RST;
    if (cfg_read_i) begin
      if (is_offset(cfg_offset_i, `CCR_OFF_CARD)) begin
        next_rdata = card_reg[cfg_func_i];
      end else if (is_offset(cfg_offset_i, `CCR_OFF_DEV)) begin
        next_rdata = dev_reg[cfg_func_i];
      end else begin
        next_rdata = `CCR_RDATA_RST;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_rdata_o  <= `CCR_RDATA_RST;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rdata_o  <= next_rdata;
      cfg_rvalid_o <= next_rvalid;
    end
  end

  // ---------------------------------------------------------------------------
  // Card services: ring, video select, audio, speaker
  // ---------------------------------------------------------------------------
  always_comb begin
    // Ring is only passed while its socket enables it
    next_ring    = |(ring_s & ring_en);
    // Priority follows socket 0's bit; a lone enabled socket always wins
    next_sel0_n  = !(vid_en[0] && (!vid_en[1] || !card_reg[0][`CCR_CC_PRIO]));
    next_sel1_n  = !(vid_en[1] && (!vid_en[0] || card_reg[0][`CCR_CC_PRIO]));
    // Audio is already a pulse stream, so it is passed as the PWM level
    next_audio   = |(aud_s & ~audio_mux);
    // Two speakers mix by exclusive-or, as on a single-bit sounder
    next_speaker = ^(spk_s & spk_en);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ring_indicate_output_o <= 1'b0;
      video_select0_n_o      <= 1'b1;
      video_select1_n_o      <= 1'b1;
      card_audio_pwm_o       <= 1'b0;
      host_speaker_out_o     <= 1'b0;
    end else begin
      ring_indicate_output_o <= next_ring;
      video_select0_n_o      <= next_sel0_n;
      video_select1_n_o      <= next_sel1_n;
      card_audio_pwm_o       <= next_audio;
      host_speaker_out_o     <= next_speaker;
    end
  end

  // ---------------------------------------------------------------------------
  // Socket power, status change routing
  // ---------------------------------------------------------------------------
  always_comb begin
    for (int s = 0; s < `CCR_NUM_SOCK; s++) begin
      next_power_off[s] = power_off[s];
      // A locked socket in D3 keeps its power whatever software asks
      if (power_off_req_i[s] && !(lock[s] && d3_state_i[s])) begin
        next_power_off[s] = 1'b1;
      end else if (power_on_req_i[s]) begin
        next_power_off[s] = 1'b0;
      end
    end
    // Routing choice itself lives in the diagnostic register outside
    next_csc = csc_route_i && (|status_change_irq_i);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      power_off           <= 2'h0;
      status_change_pci_o <= 1'b0;
    end else begin
      power_off           <= next_power_off;
      status_change_pci_o <= next_csc;
    end
  end

  assign socket_power_off_o = power_off;

  // ---------------------------------------------------------------------------
  // NAND-tree diagnostic chain
  // ---------------------------------------------------------------------------
  // Taps only synchronised inputs; no output of this bank joins the chain
  assign nand_chain[0] = !pins_sync[0];
  for (genvar i = 1; i < `CCR_NUM_PINS; i++) begin : g_nand
    assign nand_chain[i] = !(nand_chain[i-1] && pins_sync[i]);
  end

  always_comb begin
    next_nand_en  = |nand_en;
    next_nand_out = next_nand_en && nand_chain[`CCR_NUM_PINS-1];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      nand_tree_en_o  <= 1'b0;
      nand_tree_out_o <= 1'b0;
    end else begin
      nand_tree_en_o  <= next_nand_en;
      nand_tree_out_o <= next_nand_out;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  chk_ring_gate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ring_en == 2'h0) |=> !ring_indicate_output_o)
    else $error("ring output active while disabled");

  chk_video_hiz: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_card[0] |=> (video_port_hiz_o[0] == $past(cfg_wdata_i[`CCR_CC_VID])))
    else $error("video tri-state does not follow write");

  chk_video_prio: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ((vid_en == 2'h3) && !card_reg[0][`CCR_CC_PRIO]) |=>
      (!video_select0_n_o && video_select1_n_o))
    else $error("socket 0 not granted video priority");

  chk_audio_route: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (audio_mux == 2'h3) |=> !card_audio_pwm_o)
    else $error("audio driven while not routed");

  chk_speaker_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (spk_en == 2'h0) |=> !host_speaker_out_o)
    else $error("speaker output active while disabled");

  chk_power_lock: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (lock[0] && d3_state_i[0] && !power_off[0]) |=> !power_off[0])
    else $error("locked socket powered down in D3");

  chk_mode_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_dev[1] |=> (irq_signal_mode1_o == $past(cfg_wdata_i[2:1])))
    else $error("interrupt mode does not follow write");

  chk_nand_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (nand_en == 2'h0) |=> !nand_tree_out_o)
    else $error("NAND chain output while disabled");

endmodule

// File: verif/ccr_card_model.sv
// Behavioural model of the two card sockets driving their card-side pins.
// Assumes the bench asks for pin levels; pins move only after a falling edge.
`timescale 1ns/10ps

module ccr_card_model (
  // Clock and requested levels
  input  wire logic       clk_i,
  input  wire logic [7:0] want_i,
  // Card pins, one bit per socket
  output logic      [1:0] card_func_irq_o,
  output logic      [1:0] card_ring_o,
  output logic      [1:0] card_audio_o,
  output logic      [1:0] card_speaker_o
);
  // ---------------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------------
  // Pins change away from the sampling edge, so the synchroniser sees clean levels
  // One process drives the pins; the synchroniser is held in reset until they settle
  always @(negedge clk_i) begin
    card_func_irq_o <= want_i[1:0];
    card_ring_o     <= want_i[3:2];
    card_audio_o    <= want_i[5:4];
    card_speaker_o  <= want_i[7:6];
  end
endmodule

// File: verif/tb.sv
// Self-checking bench of the card/device control bank.
// Assumes the bank answers reads one cycle after the strobe edge.
`timescale 1ns/10ps

module tb
  import ccr_pkg::*;
();
  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  logic             clk_i, rst_i, cfg_write_i, cfg_read_i, cfg_func_i, csc_route_i;
  logic [7:0]       cfg_offset_i, want;
  ccr_byte_type     cfg_wdata_i, cfg_rdata_o, wd;
  logic [1:0]       card_func_irq_i, card_ring_i, card_audio_i, card_speaker_i;
  logic [1:0]       power_off_req_i, power_on_req_i, d3_state_i, status_change_irq_i;
  logic             cfg_rvalid_o, ring_indicate_output_o, video_select0_n_o;
  logic             video_select1_n_o, card_audio_pwm_o, host_speaker_out_o;
  logic             status_change_pci_o, nand_tree_en_o, nand_tree_out_o;
  logic [1:0]       video_port_hiz_o, card_irq_pending_o, socket_power_off_o;
  logic [1:0]       low_volt_capable_o, test_short_count_o;
  ccr_irq_mode_type irq_signal_mode0_o, irq_signal_mode1_o;
  int               err_total, n_compared, seed;
  ccr_byte_type     exp_q[$]; // Expected read answers, oldest first

  ccr_top u_dut (.clk_i, .rst_i, .cfg_write_i, .cfg_read_i, .cfg_func_i, .cfg_offset_i,
    .cfg_wdata_i, .cfg_rdata_o, .cfg_rvalid_o, .card_func_irq_i, .card_ring_i,
    .card_audio_i, .card_speaker_i, .power_off_req_i, .power_on_req_i, .d3_state_i,
    .status_change_irq_i, .csc_route_i, .ring_indicate_output_o, .video_port_hiz_o,
    .video_select0_n_o, .video_select1_n_o, .card_audio_pwm_o, .host_speaker_out_o,
    .card_irq_pending_o, .socket_power_off_o, .low_volt_capable_o, .test_short_count_o,
    .irq_signal_mode0_o, .irq_signal_mode1_o, .status_change_pci_o, .nand_tree_en_o,
    .nand_tree_out_o);

  ccr_card_model u_card (.clk_i, .want_i(want), .card_func_irq_o(card_func_irq_i),
    .card_ring_o(card_ring_i), .card_audio_o(card_audio_i),
    .card_speaker_o(card_speaker_i));

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // One strobe cycle, then an idle cycle so no strobe is set twice at one edge
  task automatic acc(input logic wr, input logic f, input logic [7:0] off,
                     input logic [7:0] d);
    cfg_write_i = wr;
    cfg_read_i = !wr;
    cfg_func_i = f;
    cfg_offset_i = off;
    cfg_wdata_i = d;
    @(negedge clk_i);
    cfg_write_i = 1'b0;
    cfg_read_i = 1'b0;
    @(negedge clk_i);
  endtask

  task automatic rd(input logic f, input logic [7:0] off, input logic [7:0] exp);
    exp_q.push_back(exp);
    acc(1'b0, f, off, 8'h00);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Clock, watchdog and read monitor
  // ---------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // A hang counts as a mismatch and still reaches the report
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    tally_and_finish();
  end

  // Answer stands one cycle, so the falling edge after it is the only look
  always @(negedge clk_i) begin
    if (cfg_rvalid_o === 1'b1) begin
      if (exp_q.size() > 0) begin
        chk(cfg_rdata_o, exp_q.pop_front());
      end else begin
        $display("[FAIL] t=%0t seen=%h expected=none", $time, cfg_rdata_o);
        err_total++;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    seed = 32'hd9316ea2;
    {cfg_write_i, cfg_read_i, cfg_func_i, csc_route_i, cfg_offset_i, cfg_wdata_i} = '0;
    {power_off_req_i, power_on_req_i, d3_state_i, status_change_irq_i, want} = '0;
    rst_i = 1'b1;
    // Count rising edges so the clock's first settling cannot shorten reset
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    for (int f = 0; f < 2; f++) begin
      rd(f[0], 8'h91, 8'h00);
      rd(f[0], 8'h92, 8'h66);
    end
    chk(irq_signal_mode0_o, 8'h03);
    chk(low_volt_capable_o, 8'h03);
    // All ones: reserved bits stay zero, the flag write clears nothing pending
    acc(1'b1, 1'b0, 8'h91, 8'hff);
    acc(1'b1, 1'b0, 8'h92, 8'hff);
    acc(1'b1, 1'b0, 8'h93, 8'hff);
    rd(1'b0, 8'h91, 8'he6);
    rd(1'b0, 8'h92, 8'hef);
    rd(1'b0, 8'h93, 8'h00);
    rd(1'b1, 8'h91, 8'h00);
    rd(1'b1, 8'h92, 8'h66);
    chk(test_short_count_o, 8'h01);
    chk(video_port_hiz_o, 8'h01);
    chk(nand_tree_en_o, 8'h01);
    // Socket 0 rings and speaks with its enables; socket 1 routes audio only
    for (int i = 0; i < 2; i++) begin
      want = i ? 8'h28 : 8'h54;
      cyc(4);
      chk(ring_indicate_output_o, !i);
      chk(host_speaker_out_o, !i);
      chk(card_audio_pwm_o, i);
      chk(nand_tree_out_o, 8'h01);
    end
    // Only the last chain pin high drives the enabled chain output low
    want = 8'h80;
    cyc(4);
    chk(nand_tree_out_o, 8'h00);
    want = 8'h00;
    // Both sockets in video mode; socket 0 priority bit picks the winner
    acc(1'b1, 1'b1, 8'h91, 8'h40);
    for (int p = 1; p >= 0; p--) begin
      acc(1'b1, 1'b0, 8'h91, 8'(8'hc6 | (p << 5)));
      cyc(2);
      chk(video_select0_n_o, p);
      chk(video_select1_n_o, !p);
    end
    // Functional interrupt on socket 0 only
    want = 8'h01;
    cyc(4);
    want = 8'h00;
    cyc(4);
    rd(1'b0, 8'h91, 8'hc7);
    rd(1'b1, 8'h91, 8'h40);
    acc(1'b1, 1'b0, 8'h91, 8'hc6);
    rd(1'b0, 8'h91, 8'hc7);
    acc(1'b1, 1'b0, 8'h91, 8'hc7);
    rd(1'b0, 8'h91, 8'hc6);
    chk(card_irq_pending_o, 8'h00);
    // Every delivery mode on socket 1, test bit kept at zero by software
    for (int m = 0; m < 4; m++) begin
      wd = 8'(($random(seed) & 8'he1) | (m << 1));
      acc(1'b1, 1'b1, 8'h92, wd);
      rd(1'b1, 8'h92, wd);
      chk(irq_signal_mode1_o, 8'(m));
    end
    // Power lock of socket 0 holds only while in D3
    for (int d = 1; d >= 0; d--) begin
      d3_state_i = {1'b0, d[0]};
      power_off_req_i = 2'h1;
      cyc(1);
      power_off_req_i = 2'h0;
      cyc(1);
      chk(socket_power_off_o[0], !d);
    end
    power_on_req_i = 2'h1;
    cyc(1);
    power_on_req_i = 2'h0;
    cyc(1);
    chk(socket_power_off_o[0], 8'h00);
    // Status change reaches the host only with the routing permit
    status_change_irq_i = 2'h2;
    for (int r = 0; r < 2; r++) begin
      csc_route_i = r[0];
      cyc(2);
      chk(status_change_pci_o, 8'(r));
    end
    // Second global reset brings the defaults back
    rst_i = 1'b1;
    cyc(1);
    rst_i = 1'b0;
    rd(1'b0, 8'h91, 8'h00);
    rd(1'b0, 8'h92, 8'h66);
    cyc(2);
    chk(8'(exp_q.size()), 8'h00);
    tally_and_finish();
  end
endmodule
